// ### hw/sire_exec.v
// Contract
// [RULE1] Direct store copies accumulator, one cycle
// [RULE2] Indirect store writes via selected pointer
// [RULE3] Update code: preinc, predec, postinc, postdec
// [RULE4] Relative form adds signed offset, pointer kept
// [RULE5] Pre modes adjust first, post after
// [RULE6] Pointers are 16 bits, wrap around
// [RULE7] Indirect store touches no status flag
// [RULE8] Option load copies accumulator, flags kept
// [RULE9] Soft reset resets device, clears flag
// [RULE10] Interrupt return pops stack, sets enable
// [RULE11] Subroutine return pops stack, two cycles
// [RULE12] Idle instruction only advances program counter
`timescale 1ns/1ps
`default_nettype none
`include "sire_defs.vh"

module sire_exec (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire instr_valid_i,
    input wire [`SIRE_OP_W-1:0] opcode_i,
    input wire [`SIRE_FADDR_W-1:0] file_addr_i,
    input wire ptr_sel_i,
    input wire [1:0] pointer_update_code_i,
    input wire [`SIRE_OFS_W-1:0] offset_i,
    input wire [7:0] acc_i,
    input wire [7:0] status_i,
    input wire [`SIRE_PC_W-1:0] pc_i,
    input wire [`SIRE_PC_W-1:0] stack_top_entry_i,
    input wire [7:0] irq_control_reg_i,
    input wire [7:0] power_control_reg_i,
    input wire ptr_load_i,
    input wire ptr_load_sel_i,
    input wire [`SIRE_PTR_W-1:0] ptr_load_val_i,
    output reg busy_o,
    output reg wr_en_o,
    output reg [`SIRE_PTR_W-1:0] wr_addr_o,
    output reg [7:0] wr_data_o,
    output reg [7:0] status_o,
    output reg [`SIRE_PC_W-1:0] pc_o,
    output reg pc_load_o,
    output reg stack_pop_o,
    output reg [7:0] option_reg_o,
    output reg [7:0] irq_control_reg_o,
    output reg [7:0] power_control_reg_o,
    output reg soft_reset_flag_o,
    output reg soft_reset_req_o,
    output reg [`SIRE_PTR_W-1:0] indirect_pointer0_o,
    output reg [`SIRE_PTR_W-1:0] indirect_pointer1_o
);

    // ----------------------------------------
    // Cycle counter states
    // ----------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;

    reg state_reg;
    reg [`SIRE_PTR_W-1:0] ptr_reg [0:1];
    wire [`SIRE_PTR_W-1:0] ptr_cur;
    wire [`SIRE_PTR_W-1:0] eff_addr;
    wire [`SIRE_PTR_W-1:0] ptr_upd;
    wire take;

    assign take = instr_valid_i && (state_reg == ST_IDLE);
    // No storage behind the access port: pointer picks the location
    assign ptr_cur = ptr_reg[ptr_sel_i]; // [RULE2]

    sire_ptr_calc u_calc (
        .ptr_i(ptr_cur),
        .mode_i(pointer_update_code_i),
        .rel_i(opcode_i == `SIRE_OP_STORE_REL),
        .ofs_i(offset_i),
        .addr_o(eff_addr),
        .ptr_next_o(ptr_upd)
    );

    // ----------------------------------------
    // Indirect pointers
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ptr
            always @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    ptr_reg[gi] <= `SIRE_PTR_RST;
                end else if (ce_i) begin
                    // Instruction update beats external load
                    if (take && opcode_i == `SIRE_OP_STORE_IND && ptr_sel_i == gi) begin
                        ptr_reg[gi] <= ptr_upd; // [RULE5]
                    end else if (ptr_load_i && ptr_load_sel_i == gi) begin
                        ptr_reg[gi] <= ptr_load_val_i;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Execution
    // ----------------------------------------
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            busy_o <= 1'b0;
            wr_en_o <= 1'b0;
            wr_addr_o <= `SIRE_PTR_RST;
            wr_data_o <= `SIRE_BYTE_RST;
            status_o <= `SIRE_BYTE_RST;
            pc_o <= `SIRE_PC_RST;
            pc_load_o <= 1'b0;
            stack_pop_o <= 1'b0;
            option_reg_o <= `SIRE_OPTION_RST;
            irq_control_reg_o <= `SIRE_BYTE_RST;
            power_control_reg_o <= `SIRE_BYTE_RST;
            soft_reset_flag_o <= 1'b0;
            soft_reset_req_o <= 1'b0;
            indirect_pointer0_o <= `SIRE_PTR_RST;
            indirect_pointer1_o <= `SIRE_PTR_RST;
        end else if (ce_i) begin
            wr_en_o <= 1'b0;
            pc_load_o <= 1'b0;
            stack_pop_o <= 1'b0;
            soft_reset_req_o <= 1'b0;
            // Flags pass through unchanged for every op here
            status_o <= status_i; // [RULE7]
            irq_control_reg_o <= irq_control_reg_i;
            power_control_reg_o <= power_control_reg_i;
            soft_reset_flag_o <= power_control_reg_i[`SIRE_RI_BIT];
            indirect_pointer0_o <= ptr_reg[0];
            indirect_pointer1_o <= ptr_reg[1];
            if (state_reg == ST_WAIT) begin
                // Second cycle of a return: pipeline refill
                state_reg <= ST_IDLE;
                busy_o <= 1'b0;
            end else if (take) begin
                pc_o <= pc_i + `SIRE_PC_ONE;
                case (opcode_i)
                    `SIRE_OP_IDLE: begin
                        pc_o <= pc_i + `SIRE_PC_ONE; // [RULE12]
                    end
                    `SIRE_OP_STORE_FILE: begin
                        wr_en_o <= 1'b1; // [RULE1]
                        wr_addr_o <= {{(`SIRE_PTR_W-`SIRE_FADDR_W){1'b0}}, file_addr_i};
                        wr_data_o <= acc_i;
                    end
                    `SIRE_OP_STORE_IND, `SIRE_OP_STORE_REL: begin
                        wr_en_o <= 1'b1; // [RULE2]
                        wr_addr_o <= eff_addr; // [RULE4]
                        wr_data_o <= acc_i;
                    end
                    `SIRE_OP_LOAD_OPTION: begin
                        option_reg_o <= acc_i; // [RULE8]
                    end
                    `SIRE_OP_SOFT_RESET: begin
                        soft_reset_req_o <= 1'b1; // [RULE9]
                        power_control_reg_o[`SIRE_RI_BIT] <= 1'b0; // [RULE9]
                        soft_reset_flag_o <= 1'b0;
                    end
                    `SIRE_OP_INT_RETURN: begin
                        pc_o <= stack_top_entry_i; // [RULE10]
                        pc_load_o <= 1'b1;
                        stack_pop_o <= 1'b1;
                        irq_control_reg_o[`SIRE_GIE_BIT] <= 1'b1; // [RULE10]
                        state_reg <= ST_WAIT;
                        busy_o <= 1'b1;
                    end
                    default: begin
                        pc_o <= stack_top_entry_i; // [RULE11]
                        pc_load_o <= 1'b1;
                        stack_pop_o <= 1'b1;
                        state_reg <= ST_WAIT;
                        busy_o <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ### hw/sire_ptr_calc.v
`timescale 1ns/1ps
`default_nettype none
`include "sire_defs.vh"

module sire_ptr_calc (
    input wire [`SIRE_PTR_W-1:0] ptr_i,
    input wire [1:0] mode_i,
    input wire rel_i,
    input wire [`SIRE_OFS_W-1:0] ofs_i,
    output reg [`SIRE_PTR_W-1:0] addr_o,
    output reg [`SIRE_PTR_W-1:0] ptr_next_o
);

    // ----------------------------------------
    // Effective address and pointer update
    // ----------------------------------------
    wire [`SIRE_PTR_W-1:0] ptr_inc;
    wire [`SIRE_PTR_W-1:0] ptr_dec;
    wire [`SIRE_PTR_W-1:0] ofs_ext;
    // Modulo wrap falls out of the fixed width
    assign ptr_inc = ptr_i + `SIRE_PTR_ONE; // [RULE6]
    assign ptr_dec = ptr_i - `SIRE_PTR_ONE; // [RULE6]
    assign ofs_ext = {{(`SIRE_PTR_W-`SIRE_OFS_W){ofs_i[`SIRE_OFS_W-1]}}, ofs_i};

    always @* begin
        addr_o = ptr_i;
        ptr_next_o = ptr_i;
        if (rel_i) begin
            addr_o = ptr_i + ofs_ext; // [RULE4]
            ptr_next_o = ptr_i; // [RULE4]
        end else begin
            case (mode_i) // [RULE3]
                `SIRE_MM_PREINC: begin
                    addr_o = ptr_inc; // [RULE5]
                    ptr_next_o = ptr_inc;
                end
                `SIRE_MM_PREDEC: begin
                    addr_o = ptr_dec; // [RULE5]
                    ptr_next_o = ptr_dec;
                end
                `SIRE_MM_POSTINC: begin
                    addr_o = ptr_i; // [RULE5]
                    ptr_next_o = ptr_inc;
                end
                default: begin
                    addr_o = ptr_i; // [RULE5]
                    ptr_next_o = ptr_dec;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ### include/sire_defs.vh
`ifndef SIRE_DEFS_VH
`define SIRE_DEFS_VH

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define SIRE_OP_W 3
`define SIRE_OP_IDLE 3'h0
`define SIRE_OP_STORE_FILE 3'h1
`define SIRE_OP_STORE_IND 3'h2
`define SIRE_OP_STORE_REL 3'h3
`define SIRE_OP_LOAD_OPTION 3'h4
`define SIRE_OP_SOFT_RESET 3'h5
`define SIRE_OP_INT_RETURN 3'h6
`define SIRE_OP_SUB_RETURN 3'h7

// ----------------------------------------
// Pointer update codes
// ----------------------------------------
`define SIRE_MM_PREINC 2'h0
`define SIRE_MM_PREDEC 2'h1
`define SIRE_MM_POSTINC 2'h2
`define SIRE_MM_POSTDEC 2'h3

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define SIRE_PTR_W 16
`define SIRE_FADDR_W 7
`define SIRE_OFS_W 6
`define SIRE_PC_W 15
`define SIRE_PTR_ONE 16'h0001
`define SIRE_PTR_RST 16'h0000
`define SIRE_PC_ONE 15'h0001
`define SIRE_PC_RST 15'h0000
`define SIRE_BYTE_RST 8'h00
`define SIRE_OPTION_RST 8'hff
`define SIRE_GIE_BIT 7
`define SIRE_RI_BIT 0
`define SIRE_CNT_RST 2'h0
`define SIRE_ONE_CYC 2'h1
`define SIRE_TWO_CYC 2'h2

`endif

// ### tb/sire_exec_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sire_exec_assertions (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic instr_valid_i,
    input wire logic [2:0] opcode_i,
    input wire logic [6:0] file_addr_i,
    input wire logic ptr_sel_i,
    input wire logic [1:0] pointer_update_code_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] status_i,
    input wire logic [14:0] pc_i,
    input wire logic [14:0] stack_top_entry_i,
    input wire logic busy_o,
    input wire logic wr_en_o,
    input wire logic [15:0] wr_addr_o,
    input wire logic [7:0] wr_data_o,
    input wire logic [7:0] status_o,
    input wire logic [14:0] pc_o,
    input wire logic pc_load_o,
    input wire logic stack_pop_o,
    input wire logic [7:0] option_reg_o,
    input wire logic [7:0] irq_control_reg_o,
    input wire logic [7:0] power_control_reg_o,
    input wire logic soft_reset_flag_o,
    input wire logic soft_reset_req_o,
    input wire logic [15:0] indirect_pointer0_o
);
    // ----
    // Checks
    // ----
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire take = ce_i && instr_valid_i && !busy_o;
    // Pop cycle shared by both returns
    sequence pop_cyc;
        pc_load_o && stack_pop_o && busy_o && pc_o == $past(stack_top_entry_i);
    endsequence
    chk_file_store: assert property (take && opcode_i == 3'h1 |=> wr_en_o &&
        wr_addr_o == {9'h000, $past(file_addr_i)} && wr_data_o == $past(acc_i))
        else $error("direct store wrong");
    chk_status_kept: assert property (ce_i |=> status_o == $past(status_i))
        else $error("status flags changed");
    chk_option_load: assert property (take && opcode_i == 3'h4 |=>
        option_reg_o == $past(acc_i)) else $error("option load wrong");
    chk_soft_reset: assert property (take && opcode_i == 3'h5 |=> soft_reset_req_o &&
        !soft_reset_flag_o && !power_control_reg_o[0]) else $error("soft reset wrong");
    chk_int_return: assert property (take && opcode_i == 3'h6 |=>
        pop_cyc ##0 irq_control_reg_o[7] ##1 !busy_o) else $error("interrupt return wrong");
    chk_sub_return: assert property (take && opcode_i == 3'h7 |=>
        pop_cyc ##1 !busy_o && !stack_pop_o) else $error("subroutine return wrong");
    chk_return_refuse: assert property (busy_o |=> !wr_en_o && !pc_load_o)
        else $error("request taken while busy");
    chk_idle_advance: assert property (take && opcode_i == 3'h0 |=> !wr_en_o &&
        !pc_load_o && pc_o == $past(pc_i) + 15'h0001) else $error("idle wrong");
    chk_pre_update: assert property (take && opcode_i == 3'h2 && !ptr_sel_i &&
        !pointer_update_code_i[1] |=> wr_en_o && wr_data_o == $past(acc_i)
        ##1 indirect_pointer0_o == $past(wr_addr_o)) else $error("pre update wrong");
endmodule
bind sire_exec sire_exec_assertions chk_u (.*);
`default_nettype wire

// ### tb/sire_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sire_exec_tb_top;
    reg core_clk_i = 1'h0, rst_n_i = 1'h0, ce_i = 1'h1, instr_valid_i = 1'h0, ptr_sel_i = 1'h0;
    reg ptr_load_i = 1'h0, ptr_load_sel_i = 1'h0;
    reg [2:0] opcode_i = 3'h0;
    reg [6:0] file_addr_i = 7'h00;
    reg [1:0] pointer_update_code_i = 2'h0;
    reg [5:0] offset_i = 6'h00;
    reg [7:0] acc_i = 8'h00, status_i = 8'h07, irq_control_reg_i = 8'h00;
    reg [7:0] power_control_reg_i = 8'h01;
    reg [14:0] pc_i = 15'h0100, stack_top_entry_i = 15'h0000;
    reg [15:0] ptr_load_val_i = 16'hffff, nxt;
    reg [15:0] ptr_exp [0:1];
    wire busy_o, wr_en_o, pc_load_o, stack_pop_o, soft_reset_flag_o, soft_reset_req_o;
    wire [15:0] wr_addr_o, indirect_pointer0_o, indirect_pointer1_o;
    wire [7:0] wr_data_o, status_o, option_reg_o, irq_control_reg_o, power_control_reg_o;
    wire [14:0] pc_o;
    integer err_total = 0, n_checks = 0, cycles = 0, k;
    sire_exec uut (.*);
    // ----
    // Clock, timeout, helpers
    // ----
    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cycles = cycles + 1;
        if (cycles == 400) begin
            err_total = err_total + 1;
            stop_test;
        end
    end
    task stop_test;
        if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Inputs move 1 ns after the edge, outputs read there too
    task step;
        @(posedge core_clk_i);
        #1;
    endtask
    task issue(input [2:0] op);
        opcode_i = op;
        instr_valid_i = 1'h1;
        step;
        instr_valid_i = 1'h0;
    endtask
    // ----
    // Scenarios
    // ----
    task t_file;
        acc_i = 8'h4f;
        file_addr_i = 7'h7f;
        issue(3'h1);
        check("file", {wr_en_o, wr_data_o, wr_addr_o[6:0]}, {1'h1, 8'h4f, 7'h7f});
    endtask
    // Both pointers start at the top so every mode crosses a wrap
    task t_ind;
        ptr_load_i = 1'h1;
        step;
        ptr_load_sel_i = 1'h1;
        step;
        ptr_load_i = 1'h0;
        ptr_exp[0] = 16'hffff;
        ptr_exp[1] = 16'hffff;
        for (k = 0; k < 8; k = k + 1) begin
            ptr_sel_i = k[2];
            pointer_update_code_i = k[1:0];
            acc_i = k[7:0] + 8'ha0;
            nxt = k[0] ? ptr_exp[k[2]] - 16'h0001 : ptr_exp[k[2]] + 16'h0001;
            issue(3'h2);
            check("addr", wr_addr_o, k[1] ? ptr_exp[k[2]] : nxt);
            check("data", {wr_en_o, wr_data_o}, {1'h1, acc_i});
            check("flags", status_o, status_i);
            ptr_exp[k[2]] = nxt;
            step;
            check("ptr", k[2] ? indirect_pointer1_o : indirect_pointer0_o, nxt);
        end
    endtask
    task t_rel;
        ptr_sel_i = 1'h0;
        offset_i = 6'h20;
        issue(3'h3);
        check("rel_lo", wr_addr_o, 16'hffdf);
        step;
        offset_i = 6'h1f;
        issue(3'h3);
        check("rel_hi", wr_addr_o, 16'h001e);
        step;
        check("rel_ptr", indirect_pointer0_o, 16'hffff);
    endtask
    task t_opt_idle;
        acc_i = 8'h5a;
        issue(3'h4);
        check("opt", option_reg_o, 8'h5a);
        step;
        acc_i = 8'h11;
        issue(3'h0);
        check("idle", {option_reg_o, wr_en_o, pc_o}, {8'h5a, 1'h0, 15'h0101});
    endtask
    task t_soft;
        step;
        issue(3'h5);
        check("soft", {soft_reset_req_o, soft_reset_flag_o, power_control_reg_o}, 10'h200);
    endtask
    // A request held up during the busy cycle must be dropped
    task t_ret;
        for (k = 6; k < 8; k = k + 1) begin
            step;
            stack_top_entry_i = 15'h1234 + k[14:0];
            opcode_i = k[2:0];
            instr_valid_i = 1'h1;
            step;
            check("ret_pc", pc_o, stack_top_entry_i);
            check("ret_ctl", {pc_load_o, stack_pop_o, busy_o}, 3'h7);
            check("gie", irq_control_reg_o[7], k == 6);
            opcode_i = 3'h1;
            step;
            instr_valid_i = 1'h0;
            check("refused", {wr_en_o, busy_o}, 2'h0);
        end
    endtask
    // Frozen core must ignore a pending request
    task t_ce;
        step;
        ce_i = 1'h0;
        acc_i = 8'h33;
        opcode_i = 3'h4;
        instr_valid_i = 1'h1;
        step;
        check("frozen", {option_reg_o, busy_o, wr_en_o}, {8'h5a, 2'h0});
        ce_i = 1'h1;
        instr_valid_i = 1'h0;
    endtask
    initial begin
        repeat (10) @(posedge core_clk_i);
        #1;
        rst_n_i = 1'h1;
        t_file;
        t_ind;
        t_rel;
        t_opt_idle;
        t_soft;
        t_ret;
        t_ce;
        stop_test;
    end
endmodule
`default_nettype wire
